// *** include/uch_defines.vh ***
// Register offsets, field positions, reset values and timing counts
// Assumes a 50 MHz APB clock and a 16x oversampled serial bit
`ifndef UCH_DEFINES_VH
`define UCH_DEFINES_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UCH_OFS_DATA 12'h000
`define UCH_OFS_MODEM_CTRL 12'h004
`define UCH_OFS_FEATURE 12'h008
`define UCH_OFS_FLOW_THR 12'h00C
`define UCH_OFS_TRIGGER 12'h010
`define UCH_OFS_DIVISOR 12'h014
`define UCH_OFS_STATUS 12'h018
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UCH_MCR_SEND_REQ 1
`define UCH_MCR_LOOPBACK 4
`define UCH_EFR_AUTO_RTS 6
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define UCH_MCR_RESET 8'h00
`define UCH_EFR_RESET 8'h00
`define UCH_THR_RESET 8'h4C
`define UCH_TRIG_RESET 8'h11
`define UCH_DIV_RESET 16'h001B
`define UCH_OVERSAMPLE 16
`define UCH_VOTE_FIRST 4'h7
`define UCH_VOTE_LAST 4'h9
`define UCH_TIMEOUT_TICKS 640
`endif

// *** verilog/uch_ram.v ***
// Small two-port memory for one channel FIFO
// Assumes one clock; read data appear one edge after the address
`default_nettype none
module uch_ram #(
  parameter WIDTH = 9,
  parameter ADDR_W = 4
) (
  input wire pclk,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  // ------------------------------------------------------------
  // Write and registered read
  // ------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // uch_ram
`default_nettype wire

// *** verilog/uch_channel.v ***
// One asynchronous serial channel with APB registers and pin signalling
// Assumes APB slave, bus inputs synchronous to pclk, serial_in synchronised here, 8N1 framing
`include "uch_defines.vh"
`default_nettype none
module uch_channel #(
  parameter ADDR_W = 4,
  parameter TIMEOUT_TICKS = `UCH_TIMEOUT_TICKS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_in,
  output reg serial_out,
  output reg send_request_out,
  output reg receive_ready_dma_out,
  output reg transmit_ready_dma_out
);
  localparam LW = ADDR_W + 1;
  localparam [LW-1:0] DEPTH = 1 << ADDR_W;
  localparam S_IDLE = 4'b0001;
  localparam S_START = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_STOP = 4'b1000;

  // ------------------------------------------------------------
  // Registers and bus decode
  // ------------------------------------------------------------
  reg [7:0] modem_control_reg;
  reg [7:0] enhanced_feature_reg;
  reg [7:0] flow_threshold_reg;
  reg [7:0] trigger_reg;
  reg [15:0] divisor_reg;
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire hit_data = paddr == `UCH_OFS_DATA;
  wire mapped = hit_data | (paddr == `UCH_OFS_MODEM_CTRL) | (paddr == `UCH_OFS_FEATURE) |
    (paddr == `UCH_OFS_FLOW_THR) | (paddr == `UCH_OFS_TRIGGER) |
    (paddr == `UCH_OFS_DIVISOR) | (paddr == `UCH_OFS_STATUS);
  wire loopback = modem_control_reg[`UCH_MCR_LOOPBACK];
  wire auto_rts = enhanced_feature_reg[`UCH_EFR_AUTO_RTS];

  // FIFO state
  reg [ADDR_W-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  reg [LW-1:0] tx_lvl_reg, rx_lvl_reg, rx_err_cnt_reg;
  wire [8:0] rx_q;
  wire [8:0] tx_q;
  wire tx_full = tx_lvl_reg == DEPTH;
  wire rx_empty = rx_lvl_reg == {LW{1'b0}};
  wire tx_push = wr_acc & hit_data & ~tx_full;
  wire rx_pop = rd_acc & hit_data & ~rx_empty;
  reg tx_pop;
  reg rx_push;
  reg rx_push_err;
  reg [7:0] rx_shift_reg;
  reg rx_timeout_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      modem_control_reg <= `UCH_MCR_RESET;
      enhanced_feature_reg <= `UCH_EFR_RESET;
      flow_threshold_reg <= `UCH_THR_RESET;
      trigger_reg <= `UCH_TRIG_RESET;
      divisor_reg <= `UCH_DIV_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (wr_acc)
      begin
        case (paddr)
          `UCH_OFS_MODEM_CTRL: modem_control_reg <= pwdata[7:0];
          `UCH_OFS_FEATURE: enhanced_feature_reg <= pwdata[7:0];
          `UCH_OFS_FLOW_THR: flow_threshold_reg <= pwdata[7:0];
          `UCH_OFS_TRIGGER: trigger_reg <= pwdata[7:0];
          `UCH_OFS_DIVISOR: divisor_reg <= pwdata[15:0];
          default: ;
        endcase
      end
      if (setup)
      begin
        case (paddr)
          `UCH_OFS_DATA: prdata <= {23'h000000, rx_q};
          `UCH_OFS_MODEM_CTRL: prdata <= {24'h000000, modem_control_reg};
          `UCH_OFS_FEATURE: prdata <= {24'h000000, enhanced_feature_reg};
          `UCH_OFS_FLOW_THR: prdata <= {24'h000000, flow_threshold_reg};
          `UCH_OFS_TRIGGER: prdata <= {24'h000000, trigger_reg};
          `UCH_OFS_DIVISOR: prdata <= {16'h0000, divisor_reg};
          `UCH_OFS_STATUS: prdata <= {11'h000, rx_timeout_reg, 3'h0, rx_err_cnt_reg != {LW{1'b0}},
            3'h0, rx_lvl_reg, 3'h0, tx_lvl_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // FIFO pointers, levels and memories
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_reg <= {ADDR_W{1'b0}};
      tx_rp_reg <= {ADDR_W{1'b0}};
      rx_wp_reg <= {ADDR_W{1'b0}};
      rx_rp_reg <= {ADDR_W{1'b0}};
      tx_lvl_reg <= {LW{1'b0}};
      rx_lvl_reg <= {LW{1'b0}};
      rx_err_cnt_reg <= {LW{1'b0}};
    end
    else
    begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + 1'b1;
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + 1'b1;
      tx_lvl_reg <= tx_lvl_reg + {{(LW-1){1'b0}}, tx_push} - {{(LW-1){1'b0}}, tx_pop};
      if (rx_push)
        rx_wp_reg <= rx_wp_reg + 1'b1;
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 1'b1;
      rx_lvl_reg <= rx_lvl_reg + {{(LW-1){1'b0}}, rx_push} - {{(LW-1){1'b0}}, rx_pop};
      rx_err_cnt_reg <= rx_err_cnt_reg + {{(LW-1){1'b0}}, rx_push & rx_push_err} -
        {{(LW-1){1'b0}}, rx_pop & rx_q[8]};
    end
  end

  uch_ram #(.WIDTH(9), .ADDR_W(ADDR_W)) u_tx_ram (
    .pclk(pclk),
    .wr_en(tx_push),
    .wr_addr(tx_wp_reg),
    .wr_data({1'b0, pwdata[7:0]}),
    .rd_addr(tx_rp_reg),
    .rd_data(tx_q)
  );

  uch_ram #(.WIDTH(9), .ADDR_W(ADDR_W)) u_rx_ram (
    .pclk(pclk),
    .wr_en(rx_push),
    .wr_addr(rx_wp_reg),
    .wr_data({rx_push_err, rx_shift_reg}),
    .rd_addr(rx_rp_reg),
    .rd_data(rx_q)
  );

  // ------------------------------------------------------------
  // Oversampling tick
  // ------------------------------------------------------------
  reg [15:0] baud_cnt_reg;
  reg tick_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= baud_cnt_reg == 16'h0000;
      if (baud_cnt_reg == 16'h0000)
        baud_cnt_reg <= divisor_reg - 16'h0001;
      else
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  reg [3:0] tx_state_reg;
  reg [3:0] tx_os_reg;
  reg [2:0] tx_bit_reg;
  reg [7:0] tx_shift_reg;
  reg tx_line_reg;
  reg tx_fetch_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= S_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg <= 1'b1;
      tx_fetch_reg <= 1'b0;
      tx_pop <= 1'b0;
    end
    else
    begin
      tx_pop <= 1'b0;
      case (tx_state_reg)
        S_IDLE:
        begin
          tx_line_reg <= 1'b1;
          if (tx_fetch_reg)
          begin
            tx_fetch_reg <= 1'b0;
            tx_shift_reg <= tx_q[7:0];
            tx_pop <= 1'b1;
            tx_os_reg <= 4'h0;
            tx_state_reg <= S_START;
          end
          else if (tx_lvl_reg != {LW{1'b0}} && !tx_pop)
            tx_fetch_reg <= 1'b1;
        end
        S_START:
        begin
          tx_line_reg <= 1'b0;
          if (tick_reg)
          begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == 4'hF)
            begin
              tx_bit_reg <= 3'h0;
              tx_state_reg <= S_DATA;
            end
          end
        end
        S_DATA:
        begin
          tx_line_reg <= tx_shift_reg[0];
          if (tick_reg)
          begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == 4'hF)
            begin
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7)
                tx_state_reg <= S_STOP;
            end
          end
        end
        S_STOP:
        begin
          tx_line_reg <= 1'b1;
          if (tick_reg)
          begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == 4'hF)
              tx_state_reg <= S_IDLE;
          end
        end
        default: tx_state_reg <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receiver with three-sample vote
  // ------------------------------------------------------------
  reg rx_sync1_reg, rx_sync2_reg;
  reg [3:0] rx_state_reg;
  reg [3:0] rx_os_reg;
  reg [2:0] rx_bit_reg;
  reg [2:0] rx_vote_reg;
  reg [9:0] rx_idle_reg;
  wire rx_line = loopback ? tx_line_reg : rx_sync2_reg;
  wire [2:0] votes = {rx_vote_reg[1:0], rx_line};
  wire vote_bit = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
  wire bit_mid = tick_reg && rx_os_reg == `UCH_VOTE_LAST;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sync1_reg <= 1'b1;
      rx_sync2_reg <= 1'b1;
      rx_state_reg <= S_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_vote_reg <= 3'h7;
      rx_shift_reg <= 8'h00;
      rx_push <= 1'b0;
      rx_push_err <= 1'b0;
      rx_idle_reg <= 10'h000;
      rx_timeout_reg <= 1'b0;
    end
    else
    begin
      rx_sync1_reg <= serial_in;
      rx_sync2_reg <= rx_sync1_reg;
      rx_push <= 1'b0;
      if (tick_reg)
      begin
        rx_os_reg <= rx_os_reg + 4'h1;
        if (rx_os_reg >= `UCH_VOTE_FIRST && rx_os_reg < `UCH_VOTE_LAST)
          rx_vote_reg <= {rx_vote_reg[1:0], rx_line};
      end
      case (rx_state_reg)
        S_IDLE:
        begin
          rx_os_reg <= 4'h0;
          if (!rx_line)
            rx_state_reg <= S_START;
        end
        S_START:
        begin
          if (bit_mid)
            rx_state_reg <= vote_bit ? S_IDLE : S_DATA;
          rx_bit_reg <= 3'h0;
        end
        S_DATA:
        begin
          if (bit_mid)
          begin
            rx_shift_reg <= {vote_bit, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7)
              rx_state_reg <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (bit_mid)
          begin
            rx_push <= rx_lvl_reg != DEPTH;
            rx_push_err <= ~vote_bit;
            rx_state_reg <= S_IDLE;
          end
        end
        default: rx_state_reg <= S_IDLE;
      endcase
      // Timeout after four idle character times
      if (rx_pop || rx_empty || rx_state_reg != S_IDLE)
      begin
        rx_idle_reg <= 10'h000;
        rx_timeout_reg <= 1'b0;
      end
      else if (tick_reg)
      begin
        if ({22'h000000, rx_idle_reg} == TIMEOUT_TICKS - 1)
          rx_timeout_reg <= 1'b1;
        else
          rx_idle_reg <= rx_idle_reg + 10'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin signalling: request, DMA ready lines, serial output
  // ------------------------------------------------------------
  reg rts_active_reg;
  wire [LW-1:0] halt_lvl = {1'b0, flow_threshold_reg[3:0]};
  wire [LW-1:0] resume_lvl = {1'b0, flow_threshold_reg[7:4]};
  wire [LW-1:0] rx_trig = {1'b0, trigger_reg[3:0]};
  wire [LW-1:0] tx_trig = {1'b0, trigger_reg[7:4]};
  wire [LW-1:0] tx_free = DEPTH - tx_lvl_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rts_active_reg <= 1'b1;
      send_request_out <= 1'b1;
      receive_ready_dma_out <= 1'b1;
      transmit_ready_dma_out <= 1'b1;
      serial_out <= 1'b1;
    end
    else
    begin
      if (rx_lvl_reg >= halt_lvl)
        rts_active_reg <= 1'b0;
      else if (rx_lvl_reg <= resume_lvl)
        rts_active_reg <= 1'b1;
      send_request_out <= ~(modem_control_reg[`UCH_MCR_SEND_REQ] &
        (~auto_rts | rts_active_reg));
      if (rx_empty || rx_err_cnt_reg != {LW{1'b0}})
        receive_ready_dma_out <= 1'b1;
      else if (rx_lvl_reg >= rx_trig || rx_timeout_reg)
        receive_ready_dma_out <= 1'b0;
      if (tx_full)
        transmit_ready_dma_out <= 1'b1;
      else if (tx_free >= tx_trig)
        transmit_ready_dma_out <= 1'b0;
      serial_out <= loopback ? 1'b1 : tx_line_reg;
    end
  end
endmodule // uch_channel
`default_nettype wire

// *** testbench/uch_channel_monitor.sv ***
// Port checker for one serial channel
// Bound to uch_channel from the bench top; start bits timed at divisor 1
`include "uch_defines.vh"
`default_nettype none
module uch_channel_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic send_request_out,
  input wire logic receive_ready_dma_out,
  input wire logic transmit_ready_dma_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Register shadows
  // ----
  logic [7:0] mcr_reg;
  logic auto_reg;
  logic [15:0] div_reg;
  wire wr_done = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcr_reg <= 8'h00;
      auto_reg <= 1'b0;
      div_reg <= 16'h001B;
    end
    else if (wr_done)
    begin
      if (paddr == `UCH_OFS_MODEM_CTRL) mcr_reg <= pwdata[7:0];
      if (paddr == `UCH_OFS_FEATURE) auto_reg <= pwdata[6];
      if (paddr == `UCH_OFS_DIVISOR) div_reg <= pwdata[15:0];
    end
  end
  // Frame position, so only start bits open the width check
  logic so_prev_reg;
  logic [7:0] frame_cnt_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      so_prev_reg <= 1'b1;
      frame_cnt_reg <= 8'h00;
    end
    else
    begin
      so_prev_reg <= serial_out;
      if (frame_cnt_reg != 8'h00)
        frame_cnt_reg <= frame_cnt_reg - 8'h01;
      else if (so_prev_reg && !serial_out && div_reg == 16'h0001)
        frame_cnt_reg <= 8'h9F;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_outputs: assert property (!$past(presetn) |-> serial_out && send_request_out
    && receive_ready_dma_out && transmit_ready_dma_out) else $error("outputs not idle");
  a_ready_next: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_err_decode: assert property (pready && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > `UCH_OFS_STATUS)) else $error("bad decode");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_send_req_manual: assert property (mcr_reg == $past(mcr_reg, 2)
    && auto_reg == $past(auto_reg, 2) && (!auto_reg || !mcr_reg[1])
    |-> send_request_out == !mcr_reg[1]) else $error("request pin wrong");
  a_loop_tx_idle: assert property (mcr_reg[4] && $past(mcr_reg[4], 2) |-> serial_out)
    else $error("transmit pin active in loopback");
  a_start_width: assert property ($fell(serial_out) && frame_cnt_reg == 8'h00
    && div_reg == 16'h0001 && !mcr_reg[4]
    |-> (!serial_out)[*8] ##8 !serial_out) else $error("start bit short");
endmodule // uch_channel_monitor
`default_nettype wire

// *** testbench/uch_serial_peer.sv ***
// Remote serial party: sends 8N1 frames and decodes the channel's frames
// Assumes 16 pclk cycles per bit, divisor 1
`default_nettype none
module uch_serial_peer (
  input wire logic pclk,
  output var logic line_to_dut,
  input wire logic line_from_dut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic listen = 1'b0;
  logic [7:0] got;
  event got_ev;
  initial line_to_dut = 1'b1;
  task automatic hold(input logic v);
    @(posedge pclk);
    line_to_dut <= v;
  endtask
  task automatic send_byte(input logic [7:0] b, input logic glitch);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
      for (int c = 0; c < 16; c++)
      begin
        @(posedge pclk);
        line_to_dut <= f[i] ^ (glitch && c == 8);
      end
  endtask
  always
  begin
    @(negedge line_from_dut);
    if (listen)
    begin
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (16) @(posedge pclk);
        got[i] = line_from_dut;
      end
      repeat (16) @(posedge pclk);
      -> got_ev;
    end
  end
endmodule // uch_serial_peer
`default_nettype wire

// *** testbench/uch_channel_tb_top.sv ***
// Bench top: APB master, remote serial peer, queue based checks
// Assumes the monitor and peer files are compiled first
`include "uch_defines.vh"
`default_nettype none
module uch_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, serial_in, serial_out;
  wire send_request_out, receive_ready_dma_out, transmit_ready_dma_out;
  int fails = 0;
  int compares = 0;
  int seed = 32'h03d612fa;
  logic [7:0] exp_q[$];
  logic [7:0] b0, b1;
  logic [31:0] rd;
  logic err;
  always #10 pclk = ~pclk;
  uch_channel #(.TIMEOUT_TICKS(40)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in(serial_in), .serial_out(serial_out), .send_request_out(send_request_out),
    .receive_ready_dma_out(receive_ready_dma_out),
    .transmit_ready_dma_out(transmit_ready_dma_out));
  uch_serial_peer i_peer (.pclk(pclk), .line_to_dut(serial_in), .line_from_dut(serial_out));
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask
  // ----
  // Serial result checker
  // ----
  always
  begin
    @(i_peer.got_ev);
    if (exp_q.size() == 0)
    begin
      fails++;
      $display("mismatch at %0t: unexpected serial byte", $time);
    end
    else
      check(32'(i_peer.got), 32'(exp_q.pop_front()));
  end
  initial
  begin
    #1000000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    cyc(20);
    presetn <= 1'b1;
    cyc(3);
    check(32'(send_request_out), 32'h1);
    check(32'(transmit_ready_dma_out), 32'h0);
    rdc(`UCH_OFS_MODEM_CTRL, 32'h00);
    rdc(`UCH_OFS_FEATURE, 32'h00);
    rdc(`UCH_OFS_FLOW_THR, 32'h4C);
    rdc(`UCH_OFS_TRIGGER, 32'h11);
    rdc(`UCH_OFS_DIVISOR, 32'h1B);
    rdc(12'h01C, 32'h0);
    check(32'(err), 32'h1);
    wr(`UCH_OFS_MODEM_CTRL, 8'h02);
    cyc(3);
    check(32'(send_request_out), 32'h0);
    repeat (17) wr(`UCH_OFS_DATA, 8'($random(seed)));
    cyc(3);
    check(32'(transmit_ready_dma_out), 32'h1);
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    check(32'(send_request_out), 32'h1);
    wr(`UCH_OFS_DIVISOR, 8'h01);
    cyc(32);
    i_peer.listen = 1'b1;
    repeat (3)
    begin
      b0 = 8'($random(seed));
      exp_q.push_back(b0);
      wr(`UCH_OFS_DATA, b0);
    end
    cyc(600);
    check(32'(exp_q.size()), 32'h0);
    i_peer.hold(1'b0);
    i_peer.hold(1'b1);
    cyc(20);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    i_peer.send_byte(b0, 1'b1);
    i_peer.send_byte(b1, 1'b1);
    cyc(4);
    check(32'(receive_ready_dma_out), 32'h0);
    rdc(`UCH_OFS_STATUS, 32'h0000_0200);
    rdc(`UCH_OFS_DATA, {24'h0, b0});
    rdc(`UCH_OFS_DATA, {24'h0, b1});
    cyc(2);
    check(32'(receive_ready_dma_out), 32'h1);
    wr(`UCH_OFS_MODEM_CTRL, 8'h02);
    wr(`UCH_OFS_FLOW_THR, 8'h12);
    wr(`UCH_OFS_FEATURE, 8'h40);
    cyc(3);
    check(32'(send_request_out), 32'h0);
    i_peer.send_byte(b0, 1'b0);
    i_peer.send_byte(b1, 1'b0);
    cyc(4);
    check(32'(send_request_out), 32'h1);
    rdc(`UCH_OFS_DATA, {24'h0, b0});
    cyc(3);
    check(32'(send_request_out), 32'h0);
    rdc(`UCH_OFS_DATA, {24'h0, b1});
    wr(`UCH_OFS_TRIGGER, 8'h12);
    i_peer.send_byte(b1, 1'b0);
    cyc(4);
    check(32'(receive_ready_dma_out), 32'h1);
    cyc(60);
    check(32'(receive_ready_dma_out), 32'h0);
    rdc(`UCH_OFS_DATA, {24'h0, b1});
    i_peer.hold(1'b0);
    cyc(154);
    i_peer.hold(1'b1);
    cyc(70);
    check(32'(receive_ready_dma_out), 32'h1);
    rdc(`UCH_OFS_STATUS, 32'h0011_0100);
    rdc(`UCH_OFS_DATA, 32'h0000_0100);
    wr(`UCH_OFS_MODEM_CTRL, 8'h10);
    i_peer.hold(1'b0);
    b0 = 8'($random(seed));
    wr(`UCH_OFS_DATA, b0);
    cyc(200);
    rdc(`UCH_OFS_DATA, {24'h0, b0});
    i_peer.hold(1'b1);
    report_and_stop();
  end
endmodule // uch_channel_tb_top
bind uch_channel uch_channel_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in(serial_in), .serial_out(serial_out), .send_request_out(send_request_out),
  .receive_ready_dma_out(receive_ready_dma_out),
  .transmit_ready_dma_out(transmit_ready_dma_out));
`default_nettype wire
